//--- rtl/vref_ctrl.sv
// voltage reference control: register file and reference enables
`timescale 1ns/10ps
module vref_ctrl (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rstn,
  // register port
  input  wire logic [vref_pkg::ADDR_W-1:0]    addr,
  input  wire logic [vref_pkg::DATA_W-1:0]    wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic      [vref_pkg::DATA_W-1:0]    rdata,
  // consumer requests
  input  wire logic                           comparator_req,
  input  wire logic                           converter_req,
  input  wire logic                           memory_req,
  // reference enables and level
  output logic                                comparator_ref_en,
  output logic                                converter_ref_en,
  output logic                                memory_ref_en,
  output logic      [vref_pkg::SEL_W-1:0]     comparator_level_select
);
  import vref_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [SEL_W-1:0]   level_r;
    logic [FORCE_W-1:0] force_r;
    logic [DATA_W-1:0]  rdata_r;
  } ctrl_state_t;

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;
  vref_cfg_if  cfg ();

  function automatic logic [DATA_W-1:0] zext(input logic [FORCE_W-1:0] v);
    zext = {{(DATA_W-FORCE_W){1'b0}}, v};
  endfunction : zext

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic hit_level(input logic [ADDR_W-1:0] a);
    hit_level = (a == OFS_LEVEL);
  endfunction : hit_level

  function automatic logic hit_force(input logic [ADDR_W-1:0] a);
    hit_force = (a != OFS_LEVEL);
  endfunction : hit_force

  // ****************************************
  // level decode
  // ****************************************
  function automatic logic level_reserved(input logic [SEL_W-1:0] code);
    unique case (code)
      LVL_1V024,
      LVL_2V048,
      LVL_2V500,
      LVL_4V096,
      LVL_SUPPLY: level_reserved = 1'b0;
      default:    level_reserved = 1'b1;
    endcase
  endfunction : level_reserved

  // ****************************************
  // register access
  // ****************************************
  always_comb begin
    st_nxt         = st_r;
    st_nxt.rdata_r = '0;
    if (wr) begin
      if (hit_level(addr)) begin
        st_nxt.level_r = wdata[SEL_W-1:0];
      end else begin
        st_nxt.force_r = wdata[FORCE_W-1:0];
      end
    end
    if (rd) begin
      if (hit_level(addr)) begin
        st_nxt.rdata_r = zext(st_r.level_r);
      end else begin
        st_nxt.rdata_r = zext(st_r.force_r);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{level_r: LEVEL_RESET, force_r: FORCE_RESET, rdata_r: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // enables
  // ****************************************
  assign cfg.force_bits               = st_r.force_r;
  assign cfg.req[BIT_COMPARATOR]      = comparator_req;
  assign cfg.req[BIT_CONVERTER]       = converter_req;
  assign cfg.req[BIT_MEMORY]          = memory_req;

  vref_enable u_enable (
    .clk  (clk),
    .rstn (rstn),
    .cfg  (cfg.gate)
  );

  assign comparator_ref_en       = cfg.enable[BIT_COMPARATOR];
  assign converter_ref_en        = cfg.enable[BIT_CONVERTER];
  assign memory_ref_en           = cfg.enable[BIT_MEMORY];
  assign comparator_level_select = st_r.level_r;
  assign rdata                   = st_r.rdata_r;

  // ****************************************
  // checks
  // ****************************************
  a_level_write_lands: assert property (@(posedge clk) disable iff (!rstn)
    (wr && addr == OFS_LEVEL) |=> (comparator_level_select == $past(wdata[SEL_W-1:0])))
    else $error("level write not stored");
  a_level_read_back: assert property (@(posedge clk) disable iff (!rstn)
    (rd && addr == OFS_LEVEL) |=> (rdata == zext($past(comparator_level_select))))
    else $error("level readback wrong");
  a_upper_bits_zero: assert property (@(posedge clk) disable iff (!rstn)
    (rd && addr == OFS_LEVEL) |=> (rdata[DATA_W-1:SEL_W] == '0))
    else $error("upper bits not zero");
  a_memory_force_on: assert property (@(posedge clk) disable iff (!rstn)
    (wr && addr == OFS_FORCE && wdata[BIT_MEMORY]) |=> ##1 memory_ref_en)
    else $error("memory force ignored");
  a_converter_force_on: assert property (@(posedge clk) disable iff (!rstn)
    (wr && addr == OFS_FORCE && wdata[BIT_CONVERTER]) |=> ##1 converter_ref_en)
    else $error("converter force ignored");
  a_comparator_force_on: assert property (@(posedge clk) disable iff (!rstn)
    (wr && addr == OFS_FORCE && wdata[BIT_COMPARATOR]) |=> ##1 comparator_ref_en)
    else $error("comparator force ignored");
  a_request_enables: assert property (@(posedge clk) disable iff (!rstn)
    comparator_req |=> comparator_ref_en)
    else $error("request not honoured");
  a_enable_has_cause: assert property (@(posedge clk) disable iff (!rstn)
    $rose(converter_ref_en) |-> $past(converter_req || st_r.force_r[BIT_CONVERTER]))
    else $error("converter enable without cause");
  a_idle_no_read: assert property (@(posedge clk) disable iff (!rstn)
    !rd |=> (rdata == '0))
    else $error("read data outside read slot");

  // ****************************************
  // register port checks
  // ****************************************
  a_force_write_lands: assert property (@(posedge clk) disable iff (!rstn)
    (wr && hit_force(addr)) |=> (st_r.force_r == $past(wdata[FORCE_W-1:0])))
    else $error("force write not stored");
  a_force_read_back: assert property (@(posedge clk) disable iff (!rstn)
    (rd && hit_force(addr)) |=> (rdata == zext($past(st_r.force_r))))
    else $error("force readback wrong");
  a_force_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
    (rd && hit_force(addr)) |=> (rdata[DATA_W-1:FORCE_W] == '0))
    else $error("force upper bits not zero");
  a_level_kept: assert property (@(posedge clk) disable iff (!rstn)
    !(wr && hit_level(addr)) |=> $stable(comparator_level_select))
    else $error("level changed without write");
  a_force_kept: assert property (@(posedge clk) disable iff (!rstn)
    !(wr && hit_force(addr)) |=> $stable(st_r.force_r))
    else $error("force bits changed without write");
  a_force_keeps_level: assert property (@(posedge clk) disable iff (!rstn)
    (wr && hit_force(addr)) |=> $stable(comparator_level_select))
    else $error("force write moved level");
  a_level_keeps_force: assert property (@(posedge clk) disable iff (!rstn)
    (wr && hit_level(addr)) |=> $stable(st_r.force_r))
    else $error("level write moved force bits");
  a_reserved_stored: assert property (@(posedge clk) disable iff (!rstn)
    (wr && hit_level(addr) && level_reserved(wdata[SEL_W-1:0]))
    |=> (comparator_level_select == $past(wdata[SEL_W-1:0])))
    else $error("reserved level not stored");
  a_read_no_effect: assert property (@(posedge clk) disable iff (!rstn)
    (rd && !wr)
    |=> ($stable(st_r.level_r) && $stable(st_r.force_r)))
    else $error("read changed a register");

  // ****************************************
  // request and cause checks
  // ****************************************
  a_converter_request: assert property (@(posedge clk) disable iff (!rstn)
    converter_req |=> converter_ref_en)
    else $error("converter request not honoured");
  a_memory_request: assert property (@(posedge clk) disable iff (!rstn)
    memory_req |=> memory_ref_en)
    else $error("memory request not honoured");
  a_comparator_cause: assert property (@(posedge clk) disable iff (!rstn)
    $rose(comparator_ref_en)
    |-> $past(comparator_req || st_r.force_r[BIT_COMPARATOR]))
    else $error("comparator enable without cause");
  a_memory_cause: assert property (@(posedge clk) disable iff (!rstn)
    $rose(memory_ref_en)
    |-> $past(memory_req || st_r.force_r[BIT_MEMORY]))
    else $error("memory enable without cause");
  a_enables_match: assert property (@(posedge clk) disable iff (!rstn)
    1'b1
    |=> ({memory_ref_en, converter_ref_en, comparator_ref_en} == $past(cfg.req | st_r.force_r)))
    else $error("enables differ from request or force");

  // ****************************************
  // release checks
  // ****************************************
  a_memory_auto_off: assert property (@(posedge clk) disable iff (!rstn)
    (!memory_req && !st_r.force_r[BIT_MEMORY]) |=> !memory_ref_en)
    else $error("memory reference on with no cause");
  a_converter_auto_off: assert property (@(posedge clk) disable iff (!rstn)
    (!converter_req && !st_r.force_r[BIT_CONVERTER]) |=> !converter_ref_en)
    else $error("converter reference on with no cause");
  a_comparator_auto_off: assert property (@(posedge clk) disable iff (!rstn)
    (!comparator_req && !st_r.force_r[BIT_COMPARATOR]) |=> !comparator_ref_en)
    else $error("comparator reference on with no cause");

  // ****************************************
  // cover points
  // ****************************************
  c_forced_memory:   cover property (@(posedge clk) disable iff (!rstn) memory_ref_en && !memory_req);
  c_supply_level:    cover property (@(posedge clk) disable iff (!rstn) comparator_level_select == LVL_SUPPLY);
  c_req_then_off:    cover property (@(posedge clk) disable iff (!rstn) converter_ref_en ##1 !converter_ref_en);
  c_reserved_stored: cover property (@(posedge clk) disable iff (!rstn) level_reserved(comparator_level_select));
  c_all_forced:      cover property (@(posedge clk) disable iff (!rstn) &st_r.force_r);
endmodule : vref_ctrl

//--- rtl/vref_pkg.sv
// constants and types for the voltage reference control block
// Functional notes
// - A reference turns on by itself whenever its consumer requests it, with no software action at reset defaults.
// - Writing 1 to a force-on bit holds that reference on whatever the requests are.
// - The comparator level resets to the 1.024 V code and software may change it in the level select register.
// - Level codes 0x0..0x3 give 1.024, 2.048, 2.5 and 4.096 V, 0x7 gives supply, other codes are reserved.
// - Bit 2 of the force register keeps the memory reference on when set, else on demand.
// - Bit 1 of the force register keeps the converter reference on when set, else on demand.
// - Bit 0 of the force register keeps the comparator reference on when set, else on demand.
package vref_pkg;
  localparam int          ADDR_W          = 1;
  localparam int          DATA_W          = 8;
  localparam int          SEL_W           = 3;
  localparam int          FORCE_W         = 3;
  localparam logic [0:0]  OFS_LEVEL       = 1'h0;
  localparam logic [0:0]  OFS_FORCE       = 1'h1;
  localparam logic [2:0]  LEVEL_RESET     = 3'h0;
  localparam logic [2:0]  FORCE_RESET     = 3'h0;
  localparam int          BIT_COMPARATOR  = 0;
  localparam int          BIT_CONVERTER   = 1;
  localparam int          BIT_MEMORY      = 2;

  // ****************************************
  // level codes
  // ****************************************
  typedef enum logic [2:0] {
    LVL_1V024 = 3'h0,
    LVL_2V048 = 3'h1,
    LVL_2V500 = 3'h2,
    LVL_4V096 = 3'h3,
    LVL_SUPPLY = 3'h7
  } level_t;
endpackage : vref_pkg

//--- rtl/vref_cfg_if.sv
// carrier between register file and enable logic
`timescale 1ns/10ps
interface vref_cfg_if;
  logic [vref_pkg::FORCE_W-1:0] force_bits;
  logic [vref_pkg::FORCE_W-1:0] req;
  logic [vref_pkg::FORCE_W-1:0] enable;
  modport regs (output force_bits, output req, input enable);
  modport gate (input force_bits, input req, output enable);
endinterface : vref_cfg_if

//--- rtl/vref_enable.sv
// request and force combiner for the three references
`timescale 1ns/10ps
module vref_enable (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // configuration
  vref_cfg_if.gate  cfg
);
  import vref_pkg::*;

  typedef struct packed {
    logic [FORCE_W-1:0] en_r;
  } en_state_t;

  en_state_t st_r;
  en_state_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.en_r = cfg.req | cfg.force_bits;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg.enable = st_r.en_r;

  a_force_holds_on: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.force_bits != '0) |=> ((cfg.enable & $past(cfg.force_bits)) == $past(cfg.force_bits)))
    else $error("forced reference not on");
  a_idle_goes_off: assert property (@(posedge clk) disable iff (!rstn)
    ((cfg.req | cfg.force_bits) == '0) |=> (cfg.enable == '0))
    else $error("reference on with no cause");
endmodule : vref_enable

//--- tb/vref_consumers.sv
// model of the three reference consumers
`timescale 1ns/10ps
module vref_consumers (
  // command from bench
  input  wire logic [2:0] want,
  // request lines
  output logic            comparator_req,
  output logic            converter_req,
  output logic            memory_req
);
  // the converter picks its level on its own side, only a request comes here
  assign comparator_req = want[0];
  assign converter_req  = want[1];
  assign memory_req     = want[2];
endmodule : vref_consumers

//--- tb/tb_top.sv
// bench for the voltage reference control block
`timescale 1ns/10ps
module tb_top;
  import vref_pkg::*;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [0:0] addr = 1'h0;
  logic [7:0] wdata = 8'h00;
  logic [2:0] want = 3'h0;
  logic [7:0] rdata;
  logic [2:0] lvl;
  wire  [2:0] en;
  logic       c_req;
  logic       v_req;
  logic       m_req;
  int         err_total = 0;
  int         n_tests = 0;
  always #2.5 clk = ~clk;
  vref_consumers peer (.want(want), .comparator_req(c_req), .converter_req(v_req), .memory_req(m_req));
  vref_ctrl uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .comparator_req(c_req), .converter_req(v_req), .memory_req(m_req), .comparator_ref_en(en[0]),
    .converter_ref_en(en[1]), .memory_ref_en(en[2]), .comparator_level_select(lvl));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr_reg(logic [0:0] a, logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(string name, logic [0:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(name, exp, rdata);
  endtask : rd_chk
  task automatic t_reset();
    chk("level_out", 8'h00, 8'(lvl));
    chk("enables", 8'h00, 8'(en));
    rd_chk("level_rd", 1'h0, 8'h00);
    rd_chk("force_rd", 1'h1, 8'h00);
  endtask : t_reset
  task automatic t_auto();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      want <= 3'h1 << i;
      #1 chk("en_late", 8'h00, 8'(en));
      @(posedge clk);
      want <= 3'h0;
      #1 chk("en_on", 8'(3'h1 << i), 8'(en));
      @(posedge clk);
      #1 chk("en_off", 8'h00, 8'(en));
    end
  endtask : t_auto
  task automatic t_force();
    for (int i = 0; i < 3; i++) begin
      wr_reg(1'h1, 8'hf8 | (8'h1 << i));
      @(posedge clk);
      #1 chk("force_en", 8'(3'h1 << i), 8'(en));
      rd_chk("force_rd", 1'h1, 8'(3'h1 << i));
    end
    wr_reg(1'h1, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("force_off", 8'h00, 8'(en));
  endtask : t_force
  task automatic t_level();
    logic [2:0] codes [6] = '{LVL_1V024, LVL_2V048, LVL_2V500, LVL_4V096, LVL_SUPPLY, 3'h5};
    foreach (codes[k]) begin
      wr_reg(1'h0, 8'hf8 | 8'(codes[k]));
      #1 chk("level_out", 8'(codes[k]), 8'(lvl));
      rd_chk("level_rd", 1'h0, 8'(codes[k]));
    end
  endtask : t_level
  task automatic t_rerun();
    wr_reg(1'h1, 8'h07);
    wr_reg(1'h0, 8'h03);
    #1 chk("force_all", 8'h07, 8'(en));
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 chk("level_out", 8'h00, 8'(lvl));
    chk("enables", 8'h00, 8'(en));
    rd_chk("force_rd", 1'h1, 8'h00);
    rd_chk("level_rd", 1'h0, 8'h00);
  endtask : t_rerun
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_auto();
    t_force();
    t_level();
    t_rerun();
    stop_test();
  end
  initial begin
    #20000;
    err_total++;
    stop_test();
  end
endmodule : tb_top
